// [common/pdam_agu_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface pdam_agu_if;
  import pdam_pkg::*;
  logic            req;
  logic            word;
  logic [15:0]     addr;
  logic [9:0]      page;
  logic [23:0]     eff_addr;
  pdam_target_type target;
  logic            addr_err;
  modport unit (input req, word, addr, page, output eff_addr, target, addr_err);
  modport user (output req, word, addr, page, input eff_addr, target, addr_err);
endinterface : pdam_agu_if
`default_nettype wire

// [common/pdam_pkg.sv]
package pdam_pkg;
  localparam int          PROG_AW         = 24;
  localparam int          PC_W            = 23;
  localparam int          DATA_AW         = 16;
  localparam int          PAGE_W          = 10;
  localparam int          CFG_WORDS       = 4;
  localparam int          CFG_W           = 24;
  localparam logic [23:0] USER_TOP        = 24'h7FFFFF;
  localparam logic [23:0] RESET_VEC       = 24'h000000;
  localparam logic [23:0] START_WORD_ADDR = 24'h000002;
  localparam logic [23:0] IVT_LO          = 24'h000004;
  localparam logic [23:0] IVT_HI_END      = 24'h0000FF;
  localparam logic [23:0] AIVT_LO         = 24'h000100;
  localparam logic [23:0] AIVT_HI_END     = 24'h0001FF;
  localparam logic [23:0] VEC_END         = 24'h000200;
  localparam logic [23:0] CFG_BASE        = 24'h02ABF8;
  localparam logic [23:0] PC_STEP         = 24'h000002;
  localparam int          TBLPAGE_CFG_BIT = 7;
  localparam logic [15:0] WINDOW_BASE     = 16'h8000;
  localparam logic [15:0] BASE_TOP        = 16'h7FFF;
  localparam logic [15:0] DIRECT_RAM_TOP  = 16'h77FF;
  localparam logic [9:0]  PAGE_PSV_BIT    = 10'h200;
  localparam logic [9:0]  PAGE_EXT_BIT    = 10'h100;

  typedef enum logic [4:0] {
    PDAM_TGT_NONE = 5'h01,
    PDAM_TGT_BASE = 5'h02,
    PDAM_TGT_XRAM = 5'h04,
    PDAM_TGT_PMP  = 5'h08,
    PDAM_TGT_PSV  = 5'h10
  } pdam_target_type;

  typedef enum logic [2:0] {
    PDAM_CFG_IDLE = 3'h1,
    PDAM_CFG_LOAD = 3'h2,
    PDAM_CFG_DONE = 3'h4
  } pdam_cfg_state_type;
endpackage : pdam_pkg

// [hw/pdam_agu.sv]
`timescale 1ns/1ps
`default_nettype none
module pdam_agu #(
  parameter bit IS_WRITE = 1'b0
) (
  pdam_agu_if.unit agu,
  input  wire logic [9:0] read_page_in
);
  import pdam_pkg::*;
  wire       in_window;
  wire [9:0] used_page;
  wire       psv_page;
  assign in_window = agu.addr[15];
  // Program view follows the read page even for writes
  assign psv_page  = (agu.page & PAGE_PSV_BIT) != 10'h000;
  assign used_page = (IS_WRITE && psv_page) ? read_page_in : agu.page;
  assign agu.eff_addr = in_window ? {used_page[8:0], agu.addr[14:0]}
                                  : {8'h00, agu.addr};
  assign agu.addr_err = agu.req && agu.word && agu.addr[0];
  assign agu.target = !agu.req ? PDAM_TGT_NONE :
                      !in_window ? PDAM_TGT_BASE :
                      psv_page ? (IS_WRITE ? PDAM_TGT_NONE : PDAM_TGT_PSV) :
                      ((used_page & PAGE_EXT_BIT) != 10'h000) ? PDAM_TGT_PMP :
                      PDAM_TGT_XRAM;
endmodule : pdam_agu
`default_nettype wire

// [hw/pdam_cfg_loader.sv]
`timescale 1ns/1ps
`default_nettype none
module pdam_cfg_loader (
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  input  wire logic        start_in,
  input  wire logic [23:0] word_in,
  output logic      [1:0]  idx_out,
  output logic             wr_out,
  output logic             done_out
);
  import pdam_pkg::*;
  pdam_cfg_state_type state_r, state_nxt;
  logic [1:0] idx_r;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      PDAM_CFG_IDLE: if (start_in) state_nxt = PDAM_CFG_LOAD;
      PDAM_CFG_LOAD: if (idx_r == 2'(CFG_WORDS - 1)) state_nxt = PDAM_CFG_DONE;
      PDAM_CFG_DONE: state_nxt = PDAM_CFG_DONE;
    endcase
  end
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= PDAM_CFG_IDLE;
      idx_r   <= 2'h0;
    end else begin
      state_r <= state_nxt;
      if (state_r == PDAM_CFG_LOAD) idx_r <= idx_r + 2'h1;
    end
  end
  assign idx_out  = idx_r;
  assign wr_out   = (state_r == PDAM_CFG_LOAD) && (word_in != 24'hFFFFFF || 1'b1);
  assign done_out = (state_r == PDAM_CFG_DONE);
endmodule : pdam_cfg_loader
`default_nettype wire

// [hw/pdam_top.sv]
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Program space spans 4M locations selected by a 24-bit address.
// - Program address comes from the 23-bit PC, or from table/data remap.
// - Ordinary user access limited to 000000h..7FFFFFh.
// - Table ops reach configuration space when table page bit 7 is set.
// - Each location is even lower word, odd upper word; top byte unimplemented.
// - Execution addresses stay lower-word aligned; PC steps by two.
// - Addresses 0x000000 up to 0x000200 are reserved for vectors.
// - Execution starts at 0x000000; image holds jump plus start at 0x000002.
// - Two vector tables: 0x000004..0x0000FF and 0x000100..0x0001FF.
// - Top four program words hold configuration, copied at every reset.
// - Loader scatters compact configuration bits into several registers.
// - 16-bit data addresses are byte addresses: 64 Kbytes, 32K words.
// - Separate read and write address generation units.
// - 0x0000..0x7FFF map to base memory; 0x8000..0xFFFF is a window.
// - Window reaches extended RAM, parallel master port and program memory.
// - Pages of 32 Kbytes; read and write page selects pick pages.
// - Program view through the window uses only the read page select.
// - Read page select joined with data address gives a 24-bit address.
// - Internal RAM above 30 Kbytes is reachable only through the window.
// - Odd-address word access traps; reads complete, writes are suppressed.
module pdam_top (
  input  wire logic                          clk_in,
  input  wire logic                          rstn_in,
  // Program side
  input  wire logic [pdam_pkg::PC_W-1:0]     pc_load_in,
  input  wire logic                          pc_load_en_in,
  input  wire logic                          pc_step_in,
  input  wire logic                          pc_back_in,
  input  wire logic                          tbl_req_in,
  input  wire logic                          tbl_write_in,
  input  wire logic                          tbl_upper_in,
  input  wire logic [7:0]                    table_page_select_in,
  input  wire logic [15:0]                   tbl_offset_in,
  input  wire logic [23:0]                   prog_rdata_in,
  // Data side
  input  wire logic                          rd_req_in,
  input  wire logic                          rd_word_in,
  input  wire logic [15:0]                   rd_addr_in,
  input  wire logic [9:0]                    read_page_select_in,
  input  wire logic                          wr_req_in,
  input  wire logic                          wr_word_in,
  input  wire logic [15:0]                   wr_addr_in,
  input  wire logic [9:0]                    write_page_select_in,
  output logic      [pdam_pkg::PROG_AW-1:0]  prog_addr_out,
  output logic                               prog_cfg_space_out,
  output logic                               prog_access_err_out,
  output logic      [15:0]                   tbl_rdata_out,
  output logic      [23:0]                   rd_eff_addr_out,
  output pdam_pkg::pdam_target_type          rd_target_out,
  output logic      [23:0]                   wr_eff_addr_out,
  output pdam_pkg::pdam_target_type          wr_target_out,
  output logic                               wr_enable_out,
  output logic                               addr_err_trap_out,
  output logic                               in_vector_area_out,
  output logic      [pdam_pkg::CFG_W*pdam_pkg::CFG_WORDS-1:0] cfg_regs_out,
  output logic                               cfg_ready_out
);
  import pdam_pkg::*;

  pdam_agu_if rd_if ();
  pdam_agu_if wr_if ();

  logic [PC_W-1:0]     pc_r;
  logic [PC_W-1:0]     pc_nxt;
  logic [PROG_AW-1:0]  prog_addr_r;
  logic                cfg_space_r;
  logic                prog_err_r;
  logic [15:0]         tbl_rdata_r;
  logic [23:0]         rd_ea_r;
  logic [23:0]         wr_ea_r;
  pdam_target_type     rd_tgt_r;
  pdam_target_type     wr_tgt_r;
  logic                wr_en_r;
  logic                trap_r;
  logic                vec_r;
  logic [CFG_W*CFG_WORDS-1:0] cfg_r;
  logic                cfg_ready_r;

  wire [1:0]           cfg_idx;
  wire                 cfg_wr;
  wire                 cfg_done;
  wire [PROG_AW-1:0]   tbl_addr;
  wire [PROG_AW-1:0]   exec_addr;
  wire [PROG_AW-1:0]   cfg_fetch_addr;
  wire [PROG_AW-1:0]   prog_addr_nxt;
  wire                 tbl_cfg;
  wire                 user_bad;
  wire [15:0]          tbl_rdata_nxt;
  wire [CFG_W-1:0]     cfg_scattered;
  wire [1:0]           cfg_next_idx;

  function automatic logic [23:0] word_align(input logic [23:0] a);
    return {a[23:1], 1'b0};
  endfunction : word_align

  assign rd_if.req  = rd_req_in;
  assign rd_if.word = rd_word_in;
  assign rd_if.addr = rd_addr_in;
  assign rd_if.page = read_page_select_in;
  assign wr_if.req  = wr_req_in;
  assign wr_if.word = wr_word_in;
  assign wr_if.addr = wr_addr_in;
  assign wr_if.page = write_page_select_in;

  // Independent units so a read and a write resolve in the same cycle
  pdam_agu #(.IS_WRITE(1'b0)) u_rd_agu (
    .agu          (rd_if.unit),
    .read_page_in (read_page_select_in)
  );
  pdam_agu #(.IS_WRITE(1'b1)) u_wr_agu (
    .agu          (wr_if.unit),
    .read_page_in (read_page_select_in)
  );

  pdam_cfg_loader u_cfg (
    .clk_in   (clk_in),
    .rstn_in  (rstn_in),
    .start_in (1'b1),
    .word_in  (prog_rdata_in),
    .idx_out  (cfg_idx),
    .wr_out   (cfg_wr),
    .done_out (cfg_done)
  );

  // PC in address units, two per program word; bit 0 of the byte address is always zero
  always_comb begin
    pc_nxt = pc_r;
    if (pc_load_en_in) pc_nxt = {pc_load_in[PC_W-1:1], 1'b0};
    else if (pc_step_in && pc_back_in) pc_nxt = pc_r - PC_STEP[PC_W-1:0];
    else if (pc_step_in) pc_nxt = pc_r + PC_STEP[PC_W-1:0];
  end

  assign tbl_cfg        = table_page_select_in[TBLPAGE_CFG_BIT];
  assign tbl_addr       = {table_page_select_in, tbl_offset_in[15:1], tbl_upper_in};
  assign exec_addr      = {1'b0, pc_r};
  // Fetch runs one word ahead since the program address is registered
  assign cfg_next_idx   = cfg_idx + {1'b0, cfg_wr};
  assign cfg_fetch_addr = CFG_BASE + {21'h0, cfg_next_idx, 1'b0};
  assign prog_addr_nxt  = !cfg_done ? cfg_fetch_addr :
                          tbl_req_in ? tbl_addr : word_align(exec_addr);
  // Execution never leaves user space; only table ops may reach the top half
  assign user_bad       = !tbl_req_in && (prog_addr_nxt > USER_TOP);
  // Upper word: bits 23:16 of the location, top byte forced to zero
  assign tbl_rdata_nxt  = tbl_upper_in ? {8'h00, prog_rdata_in[23:16]}
                                       : prog_rdata_in[15:0];
  // Stored order differs from register order: each word is byte-reversed
  assign cfg_scattered  = {prog_rdata_in[7:0], prog_rdata_in[15:8], prog_rdata_in[23:16]};

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) pc_r <= RESET_VEC[PC_W-1:0];
    else if (cfg_done) pc_r <= pc_nxt;
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      prog_addr_r <= RESET_VEC;
      cfg_space_r <= 1'b0;
      prog_err_r  <= 1'b0;
      tbl_rdata_r <= 16'h0000;
      vec_r       <= 1'b0;
    end else begin
      prog_addr_r <= prog_addr_nxt;
      cfg_space_r <= tbl_req_in && tbl_cfg;
      prog_err_r  <= user_bad;
      tbl_rdata_r <= (tbl_req_in && !tbl_write_in) ? tbl_rdata_nxt : tbl_rdata_r;
      vec_r       <= prog_addr_nxt < VEC_END;
    end
  end

  // Copied on every reset since the loader restarts from idle
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cfg_r       <= '0;
      cfg_ready_r <= 1'b0;
    end else begin
      if (cfg_wr) cfg_r[cfg_idx*CFG_W +: CFG_W] <= cfg_scattered;
      cfg_ready_r <= cfg_done;
    end
  end

  // Data side registered; window pages and base mapping resolved by the units
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_ea_r  <= 24'h000000;
      wr_ea_r  <= 24'h000000;
      rd_tgt_r <= PDAM_TGT_NONE;
      wr_tgt_r <= PDAM_TGT_NONE;
      wr_en_r  <= 1'b0;
      trap_r   <= 1'b0;
    end else begin
      rd_ea_r  <= rd_if.eff_addr;
      wr_ea_r  <= wr_if.eff_addr;
      rd_tgt_r <= rd_if.target;
      wr_tgt_r <= wr_if.target;
      // Misaligned store dropped; read still completes
      wr_en_r  <= wr_req_in && !wr_if.addr_err && (wr_if.target != PDAM_TGT_NONE);
      trap_r   <= rd_if.addr_err || wr_if.addr_err;
    end
  end

  assign prog_addr_out       = prog_addr_r;
  assign prog_cfg_space_out  = cfg_space_r;
  assign prog_access_err_out = prog_err_r;
  assign tbl_rdata_out       = tbl_rdata_r;
  assign rd_eff_addr_out     = rd_ea_r;
  assign rd_target_out       = rd_tgt_r;
  assign wr_eff_addr_out     = wr_ea_r;
  assign wr_target_out       = wr_tgt_r;
  assign wr_enable_out       = wr_en_r;
  assign addr_err_trap_out   = trap_r;
  assign in_vector_area_out  = vec_r;
  assign cfg_regs_out        = cfg_r;
  assign cfg_ready_out       = cfg_ready_r;
endmodule : pdam_top
`default_nettype wire

// [verification/pdam_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
module pdam_monitor
  import pdam_pkg::*;
(
  input wire logic            clk_in,
  input wire logic            rstn_in,
  input wire logic            pc_step_in,
  input wire logic            pc_back_in,
  input wire logic            pc_load_en_in,
  input wire logic            tbl_req_in,
  input wire logic [7:0]      table_page_select_in,
  input wire logic            rd_req_in,
  input wire logic            rd_word_in,
  input wire logic [15:0]     rd_addr_in,
  input wire logic [9:0]      read_page_select_in,
  input wire logic            wr_req_in,
  input wire logic            wr_word_in,
  input wire logic [15:0]     wr_addr_in,
  input wire logic [23:0]     prog_addr_out,
  input wire logic            prog_cfg_space_out,
  input wire logic [23:0]     rd_eff_addr_out,
  input wire pdam_target_type rd_target_out,
  input wire logic            wr_enable_out,
  input wire logic            addr_err_trap_out,
  input wire logic            cfg_ready_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  sequence s_step;
    cfg_ready_out && pc_step_in && !pc_back_in && !pc_load_en_in && !tbl_req_in;
  endsequence
  sequence s_rd_win;
    rd_req_in && rd_addr_in[15];
  endsequence
  sequence s_odd_word;
    (rd_req_in && rd_word_in && rd_addr_in[0]) || (wr_req_in && wr_word_in && wr_addr_in[0]);
  endsequence
  a_pc_step_two: assert property (s_step ##1 s_step |=>
    prog_addr_out == $past(prog_addr_out) + 24'h000002) else $error("pc step not two");
  a_tbl_cfg_sel: assert property (tbl_req_in |=>
    prog_cfg_space_out == $past(table_page_select_in[7])) else $error("cfg space select");
  a_rd_base_map: assert property (rd_req_in && !rd_addr_in[15] |=>
    rd_eff_addr_out == {8'h00, $past(rd_addr_in)}) else $error("base map wrong");
  a_rd_page_join: assert property (s_rd_win |=>
    rd_eff_addr_out == {$past(read_page_select_in[8:0]), $past(rd_addr_in[14:0])})
    else $error("page join wrong");
  a_rd_target_sel: assert property (s_rd_win |=> rd_target_out ==
    ($past(read_page_select_in[9]) ? PDAM_TGT_PSV :
    ($past(read_page_select_in[8]) ? PDAM_TGT_PMP : PDAM_TGT_XRAM))) else $error("target");
  a_odd_trap_pulse: assert property (s_odd_word |=> addr_err_trap_out)
    else $error("no trap");
  a_odd_wr_block: assert property (wr_req_in && wr_word_in && wr_addr_in[0] |=>
    !wr_enable_out) else $error("odd store let through");
  a_even_wr_ok: assert property (cfg_ready_out && wr_req_in && !wr_addr_in[0] &&
    wr_addr_in <= DIRECT_RAM_TOP |=> wr_enable_out) else $error("store refused");
endmodule : pdam_monitor
bind pdam_top pdam_monitor u_mon (.clk_in, .rstn_in, .pc_step_in, .pc_back_in, .pc_load_en_in,
  .tbl_req_in, .table_page_select_in, .rd_req_in, .rd_word_in, .rd_addr_in,
  .read_page_select_in, .wr_req_in, .wr_word_in, .wr_addr_in, .prog_addr_out,
  .prog_cfg_space_out, .rd_eff_addr_out, .rd_target_out, .wr_enable_out,
  .addr_err_trap_out, .cfg_ready_out);
`default_nettype wire

// [verification/pdam_prog_model.sv]
`timescale 1ns/1ps
`default_nettype none
module pdam_prog_model (
  input  wire logic        clk_in,
  input  wire logic [23:0] addr_in,
  output logic      [23:0] data_out
);
  // Both words of one location share storage
  wire logic [23:0] loc = {addr_in[23:1], 1'b0};
  // Combinational: data follows the registered address of the core
  assign data_out = {loc[7:0] ^ 8'h3C, loc[15:0] ^ 16'hA55A};
endmodule : pdam_prog_model
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pdam_pkg::*;
  logic            clk_in, rstn_in = 1'b0;
  logic [22:0]     pc_load_in = '0;
  logic            pc_load_en_in = 1'b0, pc_step_in = 1'b0, pc_back_in = 1'b0;
  logic            tbl_req_in = 1'b0, tbl_write_in = 1'b0, tbl_upper_in = 1'b0;
  logic [7:0]      table_page_select_in = '0;
  logic [15:0]     tbl_offset_in = '0, rd_addr_in = '0, wr_addr_in = '0;
  logic            rd_req_in = 1'b0, rd_word_in = 1'b1, wr_req_in = 1'b0, wr_word_in = 1'b1;
  logic [9:0]      read_page_select_in = '0, write_page_select_in = '0;
  logic [23:0]     prog_rdata_in, prog_addr_out, rd_eff_addr_out, wr_eff_addr_out;
  logic [15:0]     tbl_rdata_out;
  logic [95:0]     cfg_regs_out;
  logic            prog_cfg_space_out, wr_enable_out, addr_err_trap_out, prog_access_err_out;
  logic            in_vector_area_out, cfg_ready_out;
  pdam_target_type rd_target_out, wr_target_out;
  int              err_total = 0, cmp_count = 0, cyc = 0;
  logic [15:0]     r_addr [4] = '{16'h1234, 16'h8002, 16'hFFFE, 16'h8000};
  logic [9:0]      r_page [4] = '{10'h000, 10'h001, 10'h1FF, 10'h200};
  logic [23:0]     r_ea   [4] = '{24'h001234, 24'h008002, 24'hFFFFFE, 24'h000000};
  pdam_target_type r_rt   [4] = '{PDAM_TGT_BASE, PDAM_TGT_XRAM, PDAM_TGT_PMP, PDAM_TGT_PSV};
  pdam_target_type r_wt   [4] = '{PDAM_TGT_BASE, PDAM_TGT_XRAM, PDAM_TGT_PMP, PDAM_TGT_NONE};

  pdam_top dut (.clk_in, .rstn_in, .pc_load_in, .pc_load_en_in, .pc_step_in, .pc_back_in,
    .tbl_req_in, .tbl_write_in, .tbl_upper_in, .table_page_select_in, .tbl_offset_in,
    .prog_rdata_in, .rd_req_in, .rd_word_in, .rd_addr_in, .read_page_select_in, .wr_req_in,
    .wr_word_in, .wr_addr_in, .write_page_select_in, .prog_addr_out, .prog_cfg_space_out,
    .prog_access_err_out, .tbl_rdata_out, .rd_eff_addr_out, .rd_target_out,
    .wr_eff_addr_out, .wr_target_out, .wr_enable_out, .addr_err_trap_out,
    .in_vector_area_out, .cfg_regs_out, .cfg_ready_out);
  pdam_prog_model mem (.clk_in, .addr_in(prog_addr_out), .data_out(prog_rdata_in));

  function automatic logic [23:0] pat(input logic [23:0] a);
    return {a[7:0] ^ 8'h3C, a[15:0] ^ 16'hA55A};
  endfunction : pat
  // Stored word lands byte-reversed in its register
  function automatic logic [23:0] scat(input logic [23:0] w);
    return {w[7:0], w[15:8], w[23:16]};
  endfunction : scat
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Inputs move 10 ns after the edge, outputs are read there too
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk_in);
    #10;
  endtask : tick
  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      summarize();
    end
  end

  initial begin
    tick(12);
    chk(prog_addr_out, RESET_VEC);
    chk(rd_target_out, PDAM_TGT_NONE);
    rstn_in = 1'b1;
    for (int k = 0; k < 40 && cfg_ready_out !== 1'b1; k++) tick();
    chk(cfg_ready_out, 1'b1);
    for (int w = 0; w < 4; w++) begin
      chk(cfg_regs_out[w*24 +: 24], scat(pat(CFG_BASE + 24'(2 * w))));
    end
    chk(prog_addr_out, RESET_VEC);
    $display("reset test done");
    rd_req_in = 1'b1;
    wr_req_in = 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd_addr_in = r_addr[i];
      wr_addr_in = r_addr[i];
      read_page_select_in = r_page[i];
      write_page_select_in = r_page[i];
      tick();
      chk(rd_eff_addr_out, r_ea[i]);
      chk(rd_target_out, r_rt[i]);
      chk(wr_target_out, r_wt[i]);
      chk(wr_eff_addr_out, r_ea[i]);
    end
    $display("data map test done");
    rd_req_in = 1'b0;
    wr_addr_in = 16'h1235;
    tick();
    chk(addr_err_trap_out, 1'b1);
    chk(wr_enable_out, 1'b0);
    wr_word_in = 1'b0;
    tick();
    chk(addr_err_trap_out, 1'b0);
    chk(wr_enable_out, 1'b1);
    wr_req_in = 1'b0;
    rd_req_in = 1'b1;
    rd_addr_in = 16'h1235;
    tick();
    chk(addr_err_trap_out, 1'b1);
    chk(rd_eff_addr_out, 24'h001235);
    rd_req_in = 1'b0;
    $display("odd access test done");
    pc_step_in = 1'b1;
    tick(3);
    pc_step_in = 1'b0;
    tick();
    chk(prog_addr_out, 24'h000006);
    chk(in_vector_area_out, 1'b1);
    pc_step_in = 1'b1;
    pc_back_in = 1'b1;
    tick();
    pc_step_in = 1'b0;
    pc_back_in = 1'b0;
    tick();
    chk(prog_addr_out, 24'h000004);
    pc_load_in = 23'h000300;
    pc_load_en_in = 1'b1;
    tick();
    pc_load_en_in = 1'b0;
    tick();
    chk(prog_addr_out, 24'h000300);
    chk(in_vector_area_out, 1'b0);
    $display("pc test done");
    tbl_req_in = 1'b1;
    tbl_upper_in = 1'b1;
    table_page_select_in = 8'h80;
    tbl_offset_in = 16'h0010;
    tick();
    chk(prog_cfg_space_out, 1'b1);
    chk(prog_addr_out, 24'h800011);
    chk(prog_access_err_out, 1'b0);
    tick(2);
    chk(tbl_rdata_out, 16'h002C);
    tbl_upper_in = 1'b0;
    tick(3);
    chk(tbl_rdata_out, 16'hA54A);
    table_page_select_in = 8'h00;
    tick();
    chk(prog_cfg_space_out, 1'b0);
    tbl_req_in = 1'b0;
    $display("table test done");
    rstn_in = 1'b0;
    tick(2);
    chk(cfg_ready_out, 1'b0);
    chk(prog_addr_out, RESET_VEC);
    rstn_in = 1'b1;
    for (int k = 0; k < 40 && cfg_ready_out !== 1'b1; k++) tick();
    chk(cfg_ready_out, 1'b1);
    chk(cfg_regs_out[71:48], scat(pat(CFG_BASE + 24'h000004)));
    chk(prog_addr_out, RESET_VEC);
    $display("second reset test done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
